/* File: shared/iscc_pkg.sv */
package iscc_pkg;

  // register byte offsets on the bus
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_STATUS     = 8'h04;
  // control register field positions and reset value
  localparam int          CTRL_RUN_BIT   = 0;
  localparam int          CTRL_MC_BIT    = 1;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  // status register field positions
  localparam int          STAT_MODE_LSB  = 0;
  localparam int          STAT_ADDR_LSB  = 7;
  localparam int          STAT_CYC_LSB   = 10;
  localparam int          STAT_EARLY_LSB = 13;
  localparam int          STAT_STAGE_LSB = 16;
  localparam int          STAT_RUN_BIT   = 19;

  // one timing chain stage per clock
  localparam int          CLOCK_NS       = 50;
  localparam int          STAGE_NS       = 50;
  localparam int          STAGE_CYCLES   = (STAGE_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int          CHAIN_STAGES   = 8;
  // stage numbers for the labelled chain times
  localparam logic [2:0]  T000           = 3'h0;
  localparam logic [2:0]  T050           = 3'h1;
  localparam logic [2:0]  T100           = 3'h2;
  localparam logic [2:0]  T150           = 3'h3;
  localparam logic [2:0]  T250           = 3'h5;
  localparam logic [2:0]  T300           = 3'h6;
  localparam logic [2:0]  T350           = 3'h7;

  // index register storage location
  localparam logic [15:0] INDEX_LOC      = 16'h00ff;
  // pin synchroniser depth
  localparam int          SYNC_STAGES    = 3;

  // timing chain run state
  typedef enum logic [1:0] {CH_IDLE, CH_RUN, CH_WAIT} iscc_chain_e;

  // instruction decode and datapath conditions
  typedef struct packed {
    logic fn_zero;
    logic store_type;
    logic jump_instr;
    logic replace_add_one_instr;
    logic set_protect_instr;
    logic clear_protect_instr;
    logic exit_interrupt_instr;
    logic multiply_instr;
    logic divide_instr;
    logic shift_instr;
    logic end_addressing;
    logic index_cond;
    logic indirect;
    logic disp_zero;
    logic immediate_cond;
    logic multiply_step;
    logic divide_step;
    logic multiply_last;
    logic shift_last;
  } iscc_decode_s;

  // sequence mode flip-flops
  typedef struct packed {
    logic read_next_mode;
    logic address_mode;
    logic reg_transfer_mode;
    logic read_operand_mode;
    logic store_operand_mode;
    logic read_operand_delay;
    logic store_operand_delay;
  } iscc_mode_s;

  // addressing condition flip-flops
  typedef struct packed {
    logic read_index;
    logic immediate_operand_flag;
    logic disp_zero_flag;
  } iscc_addr_s;

  // one-hot cycle flip-flops
  typedef struct packed {
    logic a;
    logic b;
    logic c;
  } iscc_cycle_s;

endpackage

/* File: rtl/iscc_sequence_control.sv */
`timescale 1ns/1ps
`default_nettype none

module iscc_sequence_control
  import iscc_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  input  wire iscc_decode_s dec,
  input  wire logic         protect_fault,
  input  wire logic         interrupt,
  input  wire logic         storage_resume,
  input  wire logic         sweep_pin,
  input  wire logic         enter_pin,
  output iscc_mode_s        modes,
  output iscc_addr_s        addr_flags,
  output iscc_cycle_s       cycles,
  output logic [2:0]        chain_stage,
  output logic              storage_request,
  output logic [15:0]       index_ref_addr
);

  // one stage must fit one clock
  if (STAGE_CYCLES != 1) begin : g_rate_check
    $error("clock rate must give one chain stage per clock");
  end

  // ---------------- console switch synchronisers ----------------
  logic [1:0]             sw_pin;          // sweep, enter raw
  logic [1:0]             sw_level;        // filtered levels
  assign sw_pin = {sweep_pin, enter_pin};

  // three flops per switch, change taken when last two agree
  for (genvar g = 0; g < 2; g++) begin : g_sync
    logic [SYNC_STAGES-1:0] sync;          // shift chain
    logic                   level;         // accepted level
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        sync  <= '0;
        level <= 1'b0;
      end else begin
        sync  <= {sync[SYNC_STAGES-2:0], sw_pin[g]};
        level <= (sync[1] == sync[2]) ? sync[2] : level;
      end
    end
    assign sw_level[g] = level;
  end

  logic                   sweep_or_enter;  // either switch on
  assign sweep_or_enter = sw_level[1] | sw_level[0];

  // ---------------- AHB-Lite slave ----------------
  logic [31:0]            ctrl;            // control register
  logic [31:0]            next_ctrl;
  logic                   wr_pend;         // write data phase due
  logic                   next_wr_pend;
  logic [7:0]             wr_addr;         // latched write offset
  logic [7:0]             next_wr_addr;
  logic [31:0]            next_hrdata;
  logic                   mc;              // master clear pulse
  logic                   next_mc;
  logic [31:0]            status;          // live status word
  logic                   take;            // address phase accepted

  assign hreadyout = 1'b1;                 // zero wait states
  assign hresp     = 1'b0;                 // always OKAY
  assign take      = hsel & htrans[1] & hready;

  // bus decode, register write, read data capture
  always_comb begin
    next_ctrl    = ctrl;
    next_wr_pend = take & hwrite;
    next_wr_addr = take ? haddr[7:0] : wr_addr;
    next_hrdata  = hrdata;
    next_mc      = 1'b0;
    // write data phase
    if (wr_pend && wr_addr == REG_CTRL) begin
      next_ctrl          = '0;
      next_ctrl[CTRL_RUN_BIT] = hwdata[CTRL_RUN_BIT];
      next_mc            = hwdata[CTRL_MC_BIT];
    end
    // read answered from the address phase
    if (take && !hwrite) begin
      case (haddr[7:0])
        REG_CTRL:   next_hrdata = ctrl;
        REG_STATUS: next_hrdata = status;
        default:    next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  // bus registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl    <= CTRL_RESET;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h0000_0000;
      mc      <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata  <= next_hrdata;
      mc      <= next_mc;
    end
  end

  // ---------------- timing chain and cycle control ----------------
  iscc_chain_e            chain;           // run state
  iscc_chain_e            next_chain;
  logic [2:0]             next_stage;
  iscc_cycle_s            early;           // early cycle flops
  iscc_cycle_s            next_early;
  iscc_cycle_s            next_cycles;
  logic                   running;         // chain stepping
  logic                   short1;          // skip stages 3,4
  logic                   short2;          // restart after 5
  logic                   next_req;

  assign running = (chain == CH_RUN);
  assign short1  = cycles.c & (dec.shift_instr | (dec.multiply_instr & ~dec.multiply_last));
  assign short2  = cycles.c & dec.shift_instr & ~dec.shift_last;

  // chain stepping and cycle selection
  always_comb begin
    next_chain  = chain;
    next_stage  = chain_stage;
    next_early  = early;
    next_cycles = cycles;
    case (chain)
      CH_IDLE: begin
        if (ctrl[CTRL_RUN_BIT]) begin
          next_chain = CH_RUN;
        end
      end
      CH_RUN: begin
        next_stage = chain_stage + 3'h1;
        if (chain_stage == T100 && short1) begin
          next_stage = T250;
        end
        if (chain_stage == T250 && short2) begin
          next_stage = T000;
        end
        if (chain_stage == T300) begin
          next_early = '0;
          if (cycles.a) begin
            if ((modes.read_operand_mode & (dec.multiply_instr | dec.divide_instr))
                | dec.shift_instr) begin
              next_early.c = 1'b1;
            end else begin
              next_early.b = 1'b1;
            end
          end else if (cycles.c) begin
            if (dec.multiply_step | dec.divide_step) begin
              next_early.c = 1'b1;
            end else begin
              next_early.b = 1'b1;
            end
          end else begin
            next_early.a = 1'b1;
          end
        end
        if (chain_stage == T350) begin
          // B waits for resume unless immediate
          if (cycles.b && !(!modes.read_operand_mode && addr_flags.immediate_operand_flag))
          begin
            next_chain = CH_WAIT;
            next_stage = T350;
          end else if (!ctrl[CTRL_RUN_BIT]) begin
            next_chain = CH_IDLE;
            next_stage = T000;
          end
        end
        // normal flops follow early at 00
        if (next_stage == T000 && next_chain == CH_RUN) begin
          next_cycles = next_early;
        end
      end
      CH_WAIT: begin
        if (storage_resume) begin
          next_chain  = CH_RUN;
          next_stage  = T000;
          next_cycles = early;
        end
      end
      default: begin
        next_chain = CH_IDLE;
      end
    endcase
    if (mc) begin
      next_chain  = CH_IDLE;
      next_stage  = T000;
      next_early  = '{a: 1'b1, b: 1'b0, c: 1'b0};
      next_cycles = '{a: 1'b1, b: 1'b0, c: 1'b0};
    end
  end

  // request on each B entry, address mode included
  assign next_req = running & cycles.b & (chain_stage == T000)
                  & (modes.address_mode | 1'b1);

  // chain registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chain           <= CH_IDLE;
      chain_stage     <= T000;
      early           <= '{a: 1'b1, b: 1'b0, c: 1'b0};
      cycles          <= '{a: 1'b1, b: 1'b0, c: 1'b0};
      storage_request <= 1'b0;
    end else begin
      chain           <= next_chain;
      chain_stage     <= next_stage;
      early           <= next_early;
      cycles          <= next_cycles;
      storage_request <= next_req;
    end
  end

  // ---------------- sequence modes and addressing flags ----------------
  iscc_mode_s             next_modes;
  iscc_addr_s             next_addr;
  logic [15:0]            next_index_ref;
  logic                   a050, a300, b150, b300, v300, t350;
  logic                   prot_exit;       // protect set/clear or exit
  logic                   rni_set, reg_set;

  assign a050 = running & cycles.a & (chain_stage == T050);
  assign a300 = running & cycles.a & (chain_stage == T300);
  assign b150 = running & cycles.b & (chain_stage == T150);
  assign b300 = running & cycles.b & (chain_stage == T300);
  assign v300 = running & (chain_stage == T300);
  assign t350 = running & (chain_stage == T350);
  assign prot_exit = dec.set_protect_instr | dec.clear_protect_instr
                   | dec.exit_interrupt_instr;

  assign rni_set = modes.store_operand_delay
                 | (modes.read_operand_delay & ~dec.replace_add_one_instr)
                 | (modes.address_mode & dec.jump_instr & dec.end_addressing)
                 | (modes.reg_transfer_mode & ~(prot_exit | interrupt));
  assign reg_set = protect_fault
                 | (a050 & modes.read_next_mode & (sweep_or_enter | dec.fn_zero));

  // mode and flag next values
  always_comb begin
    next_modes     = modes;
    next_addr      = addr_flags;
    next_index_ref = index_ref_addr;
    if (b150) begin
      next_modes.read_next_mode = rni_set;
    end
    if (a050 && modes.read_next_mode && !dec.fn_zero && !protect_fault && !sweep_or_enter) begin
      next_modes.address_mode = 1'b1;
    end else if (v300 && !cycles.a && (modes.read_next_mode | modes.read_operand_mode
                                       | modes.store_operand_mode)) begin
      // leave address mode at V300; the fetch read-next
      // flop still stands in the entry A cycle, so only B/C count
      next_modes.address_mode = 1'b0;
    end
    if (reg_set) begin
      next_modes.reg_transfer_mode = 1'b1;
    end else if (b300) begin
      next_modes.reg_transfer_mode = 1'b0;
    end
    if (b150 && ((modes.address_mode & dec.end_addressing & ~dec.store_type & ~dec.jump_instr)
                 | (~interrupt & modes.reg_transfer_mode & prot_exit))) begin
      next_modes.read_operand_mode = 1'b1;
    end else if (b300 && (modes.read_next_mode | modes.store_operand_mode)) begin
      next_modes.read_operand_mode = 1'b0;
    end
    if (b150 && (((modes.address_mode | modes.reg_transfer_mode) & interrupt)
                 | (modes.address_mode & dec.end_addressing & dec.store_type)
                 | (modes.read_operand_delay & dec.replace_add_one_instr))) begin
      next_modes.store_operand_mode = 1'b1;
    end else if (b300 && modes.read_next_mode) begin
      next_modes.store_operand_mode = 1'b0;
    end
    if (t350) begin
      next_modes.read_operand_delay  = modes.read_operand_mode;
      next_modes.store_operand_delay = modes.store_operand_mode;
    end
    if (a300) begin
      next_addr.read_index = dec.index_cond & ~dec.indirect & ~interrupt
                           & (~modes.read_next_mode | ~dec.disp_zero);
      next_index_ref = next_addr.read_index ? INDEX_LOC : 16'h0000;
    end
    if (a300 && modes.address_mode && dec.immediate_cond) begin
      next_addr.immediate_operand_flag = 1'b1;
    end else if (a300 && !modes.address_mode) begin
      next_addr.immediate_operand_flag = 1'b0;
    end
    if (a050 && modes.read_next_mode) begin
      next_addr.disp_zero_flag = dec.disp_zero;
    end
    if (mc) begin
      next_modes     = '{read_next_mode: 1'b1, default: 1'b0};
      next_addr      = '0;
      next_index_ref = 16'h0000;
    end
  end

  // mode registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      modes          <= '{read_next_mode: 1'b1, default: 1'b0};
      addr_flags     <= '0;
      index_ref_addr <= 16'h0000;
    end else begin
      modes          <= next_modes;
      addr_flags     <= next_addr;
      index_ref_addr <= next_index_ref;
    end
  end

  // status word assembly
  always_comb begin
    status = 32'h0000_0000;
    status[STAT_MODE_LSB +: 7]  = modes;
    status[STAT_ADDR_LSB +: 3]  = addr_flags;
    status[STAT_CYC_LSB +: 3]   = cycles;
    status[STAT_EARLY_LSB +: 3] = early;
    status[STAT_STAGE_LSB +: 3] = chain_stage;
    status[STAT_RUN_BIT]        = running;
  end

  // ---------------- assertions ----------------
  property p_adr_set;
    @(posedge clock) disable iff (!rst_n)
    (a050 && modes.read_next_mode && !dec.fn_zero && !protect_fault && !sweep_or_enter && !mc)
    |=> modes.address_mode;
  endproperty
  a_adr_set: assert property (p_adr_set) else $error("address mode not set");

  property p_adr_clr;
    @(posedge clock) disable iff (!rst_n)
    ($fell(modes.address_mode) && !$past(mc)) |-> ($past(chain_stage) == T300);
  endproperty
  a_adr_clr: assert property (p_adr_clr) else $error("address mode cleared off V300");

  property p_reg_clr;
    @(posedge clock) disable iff (!rst_n)
    ($fell(modes.reg_transfer_mode) && !$past(mc)) |-> ($past(b300) && !$past(reg_set));
  endproperty
  a_reg_clr: assert property (p_reg_clr) else $error("register mode cleared badly");

  property p_fault_reg;
    @(posedge clock) disable iff (!rst_n)
    (protect_fault && !mc) |=> modes.reg_transfer_mode;
  endproperty
  a_fault_reg: assert property (p_fault_reg) else $error("fault missed register mode");

  property p_sto_clr;
    @(posedge clock) disable iff (!rst_n)
    ($fell(modes.store_operand_mode) && !$past(mc)) |-> ($past(b300) && $past(modes.read_next_mode));
  endproperty
  a_sto_clr: assert property (p_sto_clr) else $error("store cleared badly");

  property p_no_overlap;
    @(posedge clock) disable iff (!rst_n)
    $rose(modes.read_operand_mode) |-> !$rose(modes.read_next_mode);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("read-next rose with read-op");

  property p_a_len;
    @(posedge clock) disable iff (!rst_n || mc)
    (running && cycles.a && chain_stage == T000 && ctrl[CTRL_RUN_BIT]) |-> ##7 (chain_stage == T350);
  endproperty
  a_a_len: assert property (p_a_len) else $error("A cycle not 400 ns");

  property p_normal_follows;
    @(posedge clock) disable iff (!rst_n)
    $rose(cycles.b) |-> (chain_stage == T000 && $past(early.b));
  endproperty
  a_normal_follows: assert property (p_normal_follows) else $error("B set off 00");

  property p_mc;
    @(posedge clock) disable iff (!rst_n)
    mc |=> (cycles.a && early.a && modes.read_next_mode && !modes.address_mode);
  endproperty
  a_mc: assert property (p_mc) else $error("master clear state wrong");

  property p_shift;
    @(posedge clock) disable iff (!rst_n || mc)
    (running && chain_stage == T250 && short2) |=> (chain_stage == T000 && cycles.c && early.c);
  endproperty
  a_shift: assert property (p_shift) else $error("shift restart wrong");

  property p_dz;
    @(posedge clock) disable iff (!rst_n)
    ($changed(addr_flags.disp_zero_flag) && !$past(mc)) |-> ($past(a050) && $past(modes.read_next_mode));
  endproperty
  a_dz: assert property (p_dz) else $error("zero displacement moved off A050");

endmodule

`default_nettype wire

/* File: verif/iscc_storage_model.sv */
`timescale 1ns/1ps
`default_nettype none

// storage control stand-in: answers each storage request with a resume
module iscc_storage_model #(
  parameter int LATENCY = 7  // clocks from request to resume when prompt
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic slow,            // adds eight clocks of latency
  input  wire logic storage_request,
  output logic      storage_resume
);
  int count;  // clocks left until resume, 0 when idle
  int held;   // clocks the resume has stood

  // countdown from request; resume stands two clocks then drops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= 0;
      held <= 0;
      storage_resume <= 1'b0;
    end else if (storage_request) begin
      // a fresh request restarts the reference
      count <= slow ? LATENCY + 8 : LATENCY;
      storage_resume <= 1'b0;
    end else if (count == 1) begin
      count <= 0;
      held <= 0;
      storage_resume <= 1'b1;
    end else if (count > 1) begin
      count <= count - 1;
    end else if (storage_resume) begin
      // drop after two clocks so no stale resume lingers
      held <= held + 1;
      storage_resume <= (held < 1);
    end
  end
endmodule

`default_nettype wire

/* File: verif/instruction_sequence_cycle_control_test.sv */
`timescale 1ns/1ps
`default_nettype none

module instruction_sequence_cycle_control_test;
  import iscc_pkg::*;
  logic clock = 1'b0;                   // 20 MHz
  logic rst_n = 1'b0;                   // async reset
  logic hsel = 1'b0;                    // bus select
  logic [31:0] haddr = 32'h0;           // bus address
  logic [1:0] htrans = 2'b00;           // transfer kind
  logic hwrite = 1'b0;                  // write strobe
  logic [2:0] hsize = 3'h2;             // word transfers only
  logic [31:0] hwdata = 32'h0;          // write data
  wire logic hready;                    // bus ready
  wire logic hreadyout;                 // slave ready
  wire logic hresp;                     // slave response
  wire logic [31:0] hrdata;             // read data
  iscc_decode_s dec = '0;               // decode conditions
  logic protect_fault = 1'b0;           // protect fault
  logic interrupt = 1'b0;               // interrupt request
  logic slow = 1'b0;                    // slow storage
  logic sweep_pin = 1'b0;               // console switch
  logic enter_pin = 1'b0;               // console switch
  wire logic storage_resume;            // from storage model
  wire logic storage_request;           // to storage model
  iscc_mode_s modes;                    // mode flops
  iscc_addr_s addr_flags;               // addressing flops
  iscc_cycle_s cycles;                  // cycle flops
  logic [2:0] chain_stage;              // chain stage
  logic [15:0] index_ref_addr;          // index reference
  int num_errors = 0;                   // mismatches
  int tests_run = 0;                    // comparisons
  logic [31:0] q;                       // read data

  // one slave, so its ready is the bus ready
  assign hready = hreadyout;
  iscc_sequence_control u_iscc_sequence_control (.clock(clock), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dec(dec),
    .protect_fault(protect_fault), .interrupt(interrupt), .storage_resume(storage_resume),
    .sweep_pin(sweep_pin), .enter_pin(enter_pin), .modes(modes), .addr_flags(addr_flags),
    .cycles(cycles), .chain_stage(chain_stage), .storage_request(storage_request),
    .index_ref_addr(index_ref_addr));
  iscc_storage_model u_iscc_storage_model (.clock(clock), .rst_n(rst_n), .slow(slow),
    .storage_request(storage_request), .storage_resume(storage_resume));

  // clock generator
  initial begin
    forever #25 clock = ~clock;
  end

  // verdict and end of run
  task automatic finish_test();
    $display("errors %0d comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  // single word transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (hready !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(posedge clock);
      n++;
    end while (hready !== 1'b1 && n < 50);
    q = hrdata;
    if (n >= 50) begin
      num_errors++;
      finish_test();
    end
  endtask

  // bounded wait for a given cycle and chain stage, settled after the edge
  task automatic wait_at(input logic [2:0] cyc, input logic [2:0] st);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while ((cycles !== cyc || chain_stage !== st) && n < 300);
    if (n >= 300) begin
      num_errors++;
      finish_test();
    end
  endtask

  // master clear plus run with the given conditions
  task automatic start(input iscc_decode_s d, input logic intr, input logic pf);
    @(posedge clock);
    dec <= d;
    interrupt <= intr;
    protect_fault <= pf;
    ahb(1'b1, {24'h0, REG_CTRL}, 32'h3);
    // let the master clear pulse land before waiting on the chain
    @(posedge clock);
  endtask

  // reset state, unmapped read
  task automatic t_reset();
    ahb(1'b0, {24'h0, REG_STATUS}, 32'h0);
    check(q, (32'h1 << (STAT_MODE_LSB + 6)) | (32'h1 << (STAT_CYC_LSB + 2)) | (32'h1 << (STAT_EARLY_LSB + 2)), "status after reset");
    ahb(1'b0, 32'h40, 32'h0);
    check(q, 32'h0, "unmapped read");
  endtask

  // register transfer path, chain length
  task automatic t_reg(input logic intr);
    iscc_decode_s d;
    d = '0;
    d.fn_zero = 1'b1;
    start(d, intr, 1'b0);
    wait_at(3'b100, T000);
    repeat (2) @(posedge clock);
    #1;
    check({modes.reg_transfer_mode, modes.address_mode}, 2'b10, "reg mode at A050");
    repeat (5) @(posedge clock);
    #1;
    check({cycles, chain_stage}, {3'b100, T350}, "A still at 350");
    @(posedge clock);
    #1;
    check({cycles, chain_stage}, {3'b010, T000}, "B after 400 ns");
    wait_at(3'b010, 3'h4);
    check(modes.store_operand_mode, intr, "store on interrupt in reg");
    wait_at(3'b010, T350);
    check(modes.reg_transfer_mode, 1'b0, "reg clears at B300");
  endtask

  // address path into read operand or store, or protect fault into register
  task automatic t_adr(input logic st, input logic pf);
    iscc_decode_s d;
    d = '0;
    d.store_type = st;
    d.end_addressing = 1'b1;
    d.index_cond = 1'b1;
    start(d, 1'b0, pf);
    wait_at(3'b100, T100);
    check({modes.address_mode, modes.reg_transfer_mode}, {!pf, pf}, "adr or fault");
    wait_at(3'b100, T350);
    check({addr_flags.read_index, index_ref_addr}, {1'b1, INDEX_LOC}, "index ref");
    wait_at(3'b010, 3'h1);
    check(storage_request, 1'b1, "storage request");
    if (!pf) begin
      wait_at(3'b010, 3'h4);
      check({modes.read_operand_mode, modes.store_operand_mode}, {!st, st}, "rop or sto");
      check(modes.read_next_mode, 1'b0, "rni clears at B150");
      wait_at(3'b010, T350);
      check(modes.address_mode, 1'b0, "adr clears at V300");
    end
    wait_at(3'b010, T350);
    @(posedge clock);
    #1;
    check({cycles, chain_stage}, {3'b010, T350}, "B holds for resume");
    slow <= 1'b1;
    wait_at(3'b100, T000);
    check(storage_resume, 1'b1, "A entered on resume");
    slow <= 1'b0;
  endtask

  // protect instruction: register, read operand, then read-next
  task automatic t_prot();
    iscc_decode_s d;
    d = '0;
    d.fn_zero = 1'b1;
    d.set_protect_instr = 1'b1;
    start(d, 1'b0, 1'b0);
    wait_at(3'b010, 3'h4);
    check({modes.read_operand_mode, modes.read_next_mode}, 2'b10, "rop after reg");
    wait_at(3'b100, T000);
    wait_at(3'b010, T350);
    check({modes.read_operand_mode, modes.read_next_mode}, 2'b01, "rni after rop");
  endtask

  // shift: short C cycles repeat until the last one
  task automatic t_shift();
    iscc_decode_s d;
    d = '0;
    d.fn_zero = 1'b1;
    d.shift_instr = 1'b1;
    start(d, 1'b0, 1'b0);
    wait_at(3'b001, T000);
    repeat (3) @(posedge clock);
    #1;
    check({cycles, chain_stage}, {3'b001, T250}, "shift C skips to five");
    @(posedge clock);
    #1;
    check({cycles, chain_stage}, {3'b001, T000}, "shift C restarts");
    @(posedge clock);
    dec.shift_last <= 1'b1;
    wait_at(3'b001, T350);
    @(posedge clock);
    #1;
    check({cycles, chain_stage}, {3'b010, T000}, "B after last shift");
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_reg(1'b0);
    t_reg(1'b1);
    t_adr(1'b0, 1'b0);
    t_adr(1'b1, 1'b0);
    t_adr(1'b0, 1'b1);
    t_prot();
    t_shift();
    finish_test();
  end
endmodule

`default_nettype wire
